// File: rtl/perfmon_pkg.sv
// Shared constants and types for the uncore perf counter global unit
package perfmon_pkg;
  // ==========================================================================
  // Register addresses on the model-specific register port
  localparam logic [15:0] CTL_ADDR = 16'h0C00;
  localparam logic [15:0] STATUS_ADDR = 16'h0C01;
  localparam logic [15:0] CFG_ADDR = 16'h0C06;

  // ==========================================================================
  // Control field positions
  localparam int FREEZE_BIT = 31;
  localparam int WAKE_BIT = 30;
  localparam int UNFREEZE_BIT = 29;
  localparam int MASK_LSB = 0;
  localparam int MASK_W = 15;

  // ==========================================================================
  // Status and configuration layout
  localparam int STATUS_W = 27;
  localparam int SLICE_LSB = 3;
  localparam int SLICE_W = 15;
  localparam int CFG_W = 4;

  // ==========================================================================
  // Reset values
  localparam logic WAKE_RESET = 1'h0;
  localparam logic [MASK_W-1:0] MASK_RESET = 15'h0000;
  localparam logic FREEZE_RESET = 1'h0;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 27'h0000000;
  localparam logic [CFG_W-1:0] SLICE_SETS_RESET = 4'h8;

  // ==========================================================================
  // Register access request and answer
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } msr_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic err;
  } msr_rsp_t;

  // Overflow sources, ordered exactly as the status register bits 26:0
  typedef struct packed {
    logic ovf_pcie_ring_stop;
    logic ovf_link_ring_stop1;
    logic ovf_link_ring_stop0;
    logic ovf_coherent_link1;
    logic ovf_coherent_link0;
    logic ovf_memory_ctrl1;
    logic ovf_memory_ctrl0;
    logic ovf_home_agent1;
    logic ovf_home_agent0;
    logic [SLICE_W-1:0] ovf_cache_slice;
    logic ovf_power_unit;
    logic ovf_utility_programmable;
    logic ovf_utility_cycle_counter;
  } ovf_src_t;

  // Per-core notification sequence
  typedef enum logic [1:0] {
    NTF_IDLE,
    NTF_WAKING,
    NTF_SEND
  } notify_state_t;
endpackage : perfmon_pkg

// File: rtl/core_notifier.sv
// Wake-then-notify sequencer for one core
`timescale 1ns/100ps
module core_notifier (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // From the global unit
  input wire logic trigger_in,
  input wire logic wake_mode_in,
  // Core side
  input wire logic awake_in,
  output logic wake_out,
  output logic notify_out
);
  perfmon_pkg::notify_state_t state_r;
  perfmon_pkg::notify_state_t state_nxt;

  // ==========================================================================
  // Sequence; a trigger during a running sequence merges into it
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      perfmon_pkg::NTF_IDLE:
      begin
        if (trigger_in && awake_in)
          state_nxt = perfmon_pkg::NTF_SEND;
        else if (trigger_in && wake_mode_in)
          state_nxt = perfmon_pkg::NTF_WAKING;
      end
      perfmon_pkg::NTF_WAKING:
      begin
        if (awake_in)
          state_nxt = perfmon_pkg::NTF_SEND;
      end
      perfmon_pkg::NTF_SEND:
        state_nxt = perfmon_pkg::NTF_IDLE;
      default:
        state_nxt = perfmon_pkg::NTF_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      state_r <= perfmon_pkg::NTF_IDLE;
    else
      state_r <= state_nxt;
  end

  // Outputs decode the state flop only, so they are glitch free
  assign wake_out = (state_r == perfmon_pkg::NTF_WAKING);
  assign notify_out = (state_r == perfmon_pkg::NTF_SEND);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_notify_one_cycle: assert property (
    notify_out |=> !notify_out)
    else $error("notify lasted more than one cycle");
  a_sleep_no_notify: assert property (
    (state_r == perfmon_pkg::NTF_IDLE) && trigger_in && !awake_in
      && !wake_mode_in |=> !notify_out && !wake_out)
    else $error("sleeping core touched without wake option");
  a_wake_before_notify: assert property (
    wake_out && awake_in |=> notify_out && !wake_out)
    else $error("notify did not follow wake");
endmodule : core_notifier

// File: rtl/perfmon_global.sv
// Global control, overflow status and configuration of the perf counters
`timescale 1ns/100ps
module perfmon_global #(
  parameter int NUM_CORES = 15
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire perfmon_pkg::msr_req_t msr_req_in,
  output perfmon_pkg::msr_rsp_t msr_rsp_out,
  // Overflow messages from the boxes, one-cycle pulses
  input wire perfmon_pkg::ovf_src_t ovf_src_in,
  // Freeze broadcast to every box
  output logic freeze_out,
  // Core side
  input wire logic [NUM_CORES-1:0] core_awake_in,
  output logic [NUM_CORES-1:0] core_wake_out,
  output logic [NUM_CORES-1:0] core_notify_out
);
  // ==========================================================================
  // Elaboration check: the mask has one bit per supported core
  if (NUM_CORES < 1 || NUM_CORES > perfmon_pkg::MASK_W)
  begin : g_bad_cores
    $error("NUM_CORES must be 1 to 15");
  end

  localparam int SW = perfmon_pkg::STATUS_W;
  localparam int MW = perfmon_pkg::MASK_W;
  localparam int CW = perfmon_pkg::CFG_W;

  logic wake_r;
  logic wake_nxt;
  logic [MW-1:0] mask_r;
  logic [MW-1:0] mask_nxt;
  logic freeze_r;
  logic freeze_nxt;
  logic [SW-1:0] status_r;
  logic [SW-1:0] status_nxt;
  logic [CW-1:0] cfg_r;
  logic [CW-1:0] cfg_nxt;
  perfmon_pkg::msr_rsp_t rsp_r;
  perfmon_pkg::msr_rsp_t rsp_nxt;

  logic [SW-1:0] ovf_vec;
  logic ovf_any;
  logic ctl_wr;
  logic st_wr;
  logic cfg_wr;
  logic [SW-1:0] clr_mask;
  logic access;

  // ==========================================================================
  // Decode
  assign ovf_vec = ovf_src_in;
  assign ovf_any = |ovf_vec;
  assign access = msr_req_in.wr || msr_req_in.rd;
  assign ctl_wr = msr_req_in.wr && (msr_req_in.addr == perfmon_pkg::CTL_ADDR);
  assign st_wr = msr_req_in.wr
    && (msr_req_in.addr == perfmon_pkg::STATUS_ADDR);
  assign cfg_wr = msr_req_in.wr && (msr_req_in.addr == perfmon_pkg::CFG_ADDR);
  assign clr_mask = st_wr ? msr_req_in.wdata[SW-1:0] : {SW{1'b0}};

  // ==========================================================================
  // Control register and freeze state
  // Freeze beats unfreeze so an overflow in the same cycle is never lost
  always_comb
  begin
    wake_nxt = wake_r;
    mask_nxt = mask_r;
    freeze_nxt = freeze_r;
    if (ctl_wr)
    begin
      wake_nxt = msr_req_in.wdata[perfmon_pkg::WAKE_BIT];
      mask_nxt = msr_req_in.wdata[perfmon_pkg::MASK_LSB +: MW];
    end
    if (ctl_wr && msr_req_in.wdata[perfmon_pkg::UNFREEZE_BIT])
      freeze_nxt = 1'h0;
    if ((ctl_wr && msr_req_in.wdata[perfmon_pkg::FREEZE_BIT]) || ovf_any)
      freeze_nxt = 1'h1;
  end

  // Control registers
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wake_r <= perfmon_pkg::WAKE_RESET;
      mask_r <= perfmon_pkg::MASK_RESET;
      freeze_r <= perfmon_pkg::FREEZE_RESET;
    end
    else
    begin
      wake_r <= wake_nxt;
      mask_r <= mask_nxt;
      freeze_r <= freeze_nxt;
    end
  end

  // Boxes hold their counts for as long as this level stands
  assign freeze_out = freeze_r;

  // ==========================================================================
  // Overflow status: set wins over a same-cycle clear
  always_comb
  begin
    status_nxt = (status_r & ~clr_mask) | ovf_vec;
  end

  // Status register
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      status_r <= perfmon_pkg::STATUS_RESET;
    else
      status_r <= status_nxt;
  end

  // ==========================================================================
  // Configuration: slice counter set count
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (cfg_wr)
      cfg_nxt = msr_req_in.wdata[CW-1:0];
  end

  // Configuration register
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      cfg_r <= perfmon_pkg::SLICE_SETS_RESET;
    else
      cfg_r <= cfg_nxt;
  end

  // ==========================================================================
  // Answer, one cycle after any access; unmapped reads zero with error
  always_comb
  begin
    rsp_nxt = '0;
    rsp_nxt.ack = access;
    case (msr_req_in.addr)
      perfmon_pkg::CTL_ADDR:
      begin
        // Command bits and reserved 28:27 always read as zero
        rsp_nxt.rdata[perfmon_pkg::WAKE_BIT] = wake_r;
        rsp_nxt.rdata[perfmon_pkg::MASK_LSB +: MW] = mask_r;
      end
      perfmon_pkg::STATUS_ADDR:
        rsp_nxt.rdata[SW-1:0] = status_r;
      perfmon_pkg::CFG_ADDR:
        rsp_nxt.rdata[CW-1:0] = cfg_r;
      default:
        rsp_nxt.err = access;
    endcase
    if (!msr_req_in.rd)
      rsp_nxt.rdata = 32'h00000000;
  end

  // Answer register
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      rsp_r <= '0;
    else
      rsp_r <= rsp_nxt;
  end

  assign msr_rsp_out = rsp_r;

  // ==========================================================================
  // Per-core notification; only cores picked by the mask see the overflow
  for (genvar i = 0; i < NUM_CORES; i++)
  begin : g_core
    core_notifier u_notifier (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .trigger_in(ovf_any && mask_r[i]),
      .wake_mode_in(wake_r),
      .awake_in(core_awake_in[i]),
      .wake_out(core_wake_out[i]),
      .notify_out(core_notify_out[i])
    );
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_freeze_cmd_acts: assert property (
    ctl_wr && msr_req_in.wdata[perfmon_pkg::FREEZE_BIT] |=> freeze_out)
    else $error("freeze command did not freeze");
  a_unfreeze_cmd_acts: assert property (
    ctl_wr && msr_req_in.wdata[perfmon_pkg::UNFREEZE_BIT]
      && !msr_req_in.wdata[perfmon_pkg::FREEZE_BIT] && !ovf_any
      |=> !freeze_out)
    else $error("unfreeze command did not unfreeze");
  a_ovf_freezes: assert property (
    ovf_any |=> freeze_out)
    else $error("overflow did not raise freeze");
  a_freeze_holds: assert property (
    freeze_out && !(ctl_wr && msr_req_in.wdata[perfmon_pkg::UNFREEZE_BIT])
      |=> freeze_out)
    else $error("freeze dropped without unfreeze");
  a_status_sticky: assert property (
    1'b1 |=> (($past(status_r) & ~$past(clr_mask)) & ~status_r) == '0)
    else $error("status flag lost without clear");
  a_status_capture: assert property (
    ovf_any |=> (status_r & $past(ovf_vec)) == $past(ovf_vec))
    else $error("overflow not recorded in status");
  a_ctl_cmd_read_zero: assert property (
    msr_req_in.rd && (msr_req_in.addr == perfmon_pkg::CTL_ADDR)
      |=> msr_rsp_out.ack && !msr_rsp_out.rdata[perfmon_pkg::FREEZE_BIT]
      && !msr_rsp_out.rdata[perfmon_pkg::UNFREEZE_BIT])
    else $error("command bits read nonzero");
  a_cfg_read_upper_zero: assert property (
    msr_req_in.rd && (msr_req_in.addr == perfmon_pkg::CFG_ADDR)
      |=> msr_rsp_out.rdata[31:CW] == '0
      && msr_rsp_out.rdata[CW-1:0] == $past(cfg_r))
    else $error("config read wrong");
  a_zero_mask_silent: assert property (
    ovf_any && mask_r == '0 && core_notify_out == '0
      && core_wake_out == '0 |=> core_notify_out == '0 && core_wake_out == '0)
    else $error("notify with empty mask");
endmodule : perfmon_global

// File: bench/core_model.sv
// Behavioural model of the cores that receive overflow notifications
`timescale 1ns/100ps
module core_model #(
  parameter int NUM_CORES = 15,
  parameter int WAKE_LAT = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Bench sends cores to sleep with a one-cycle pulse
  input wire logic [NUM_CORES-1:0] sleep_in,
  // Wake requests in, awake levels out
  input wire logic [NUM_CORES-1:0] wake_in,
  output logic [NUM_CORES-1:0] awake_out
);
  logic [NUM_CORES-1:0] asleep_r;
  int wait_r;
  // ==========================================================================
  // Wake timer
  // A slow wake proves the request is held; one timer serves all cores
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      asleep_r <= '0;
      wait_r <= 0;
    end
    else if (|(wake_in & asleep_r))
    begin
      wait_r <= wait_r + 1;
      if (wait_r == WAKE_LAT)
      begin
        asleep_r <= asleep_r & ~wake_in;
        wait_r <= 0;
      end
    end
    else
      asleep_r <= asleep_r | sleep_in;
  end
  // Awake level seen by the global unit
  assign awake_out = ~asleep_r;
endmodule : core_model

// File: bench/test_perfmon_global.sv
// Self-checking bench for the global perf counter control unit
`timescale 1ns/100ps
module test_perfmon_global;
  localparam logic [15:0] CTL = perfmon_pkg::CTL_ADDR;
  localparam logic [15:0] STA = perfmon_pkg::STATUS_ADDR;
  localparam logic [15:0] CFG = perfmon_pkg::CFG_ADDR;
  // ==========================================================================
  // Clock, reset and design signals
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  perfmon_pkg::msr_req_t req = '0;
  perfmon_pkg::msr_rsp_t rsp;
  perfmon_pkg::ovf_src_t ovf = '0;
  logic freeze;
  logic [14:0] awake, wake, notify;
  logic [14:0] sleep = 15'h0000;
  logic [31:0] rd_v;
  int bad_count = 0;
  int checked = 0;
  int n;
  // Free-running 20 MHz clock
  initial forever #25 clk_in = ~clk_in;
  perfmon_global #(.NUM_CORES(15)) dut_u (.clk_in(clk_in),
    .reset_in(reset_in), .msr_req_in(req), .msr_rsp_out(rsp),
    .ovf_src_in(ovf), .freeze_out(freeze), .core_awake_in(awake),
    .core_wake_out(wake), .core_notify_out(notify));
  core_model #(.NUM_CORES(15), .WAKE_LAT(4)) cores_u (.clk_in(clk_in),
    .reset_in(reset_in), .sleep_in(sleep), .wake_in(wake),
    .awake_out(awake));
  // ==========================================================================
  // Tasks
  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  // One register access; the answer is sampled after the ack edge
  task automatic msr_access(input logic wr, input logic [15:0] addr,
                            input logic [31:0] data);
    @(posedge clk_in);
    req <= '{wr: wr, rd: ~wr, addr: addr, wdata: data};
    @(posedge clk_in);
    req <= '0;
    #1;
    rd_v = rsp.rdata;
    check_val("ack", 32'h1, {31'h0, rsp.ack});
  endtask : msr_access
  task automatic msr_read(input logic [15:0] addr, input logic [31:0] exp,
                          input string what);
    msr_access(1'b0, addr, 32'h0);
    check_val(what, exp, rd_v);
  endtask : msr_read
  // One-cycle overflow pulse; returns when its effects are visible
  task automatic pulse(input logic [26:0] v);
    @(posedge clk_in);
    ovf <= perfmon_pkg::ovf_src_t'(v);
    @(posedge clk_in);
    ovf <= '0;
    #1;
  endtask : pulse
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk_in);
    bad_count++;
    final_report();
  end
  // ==========================================================================
  // Test sequence
  initial
  begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    msr_read(CTL, 32'h0, "ctl reset");
    msr_read(STA, 32'h0, "status reset");
    msr_read(CFG, 32'h8, "cfg reset");
    msr_access(1'b1, CFG, 32'hFFFFFFF5);
    msr_read(CFG, 32'h5, "cfg rw");
    msr_access(1'b0, 16'h0C02, 32'h0);
    check_val("unmapped err", 32'h1, {31'h0, rsp.err});
    check_val("unmapped data", 32'h0, rd_v);
    // Reserved bits 28:27 are always written as zero
    msr_access(1'b1, CTL, 32'h80004003);
    check_val("freeze", 32'h1, {31'h0, freeze});
    msr_read(CTL, 32'h00004003, "ctl readback");
    msr_access(1'b1, CTL, 32'h20004003);
    check_val("unfreeze", 32'h0, {31'h0, freeze});
    // Every source bit in turn: set, survive a zero write, clear on one
    for (int i = 0; i < 27; i++)
    begin
      pulse(27'h1 << i);
      check_val("ovf freeze", 32'h1, {31'h0, freeze});
      check_val("notify", 32'h4003, {17'h0, notify});
      msr_access(1'b1, STA, 32'h0);
      msr_read(STA, 32'h1 << i, "status flag");
      msr_access(1'b1, STA, 32'h1 << i);
      msr_read(STA, 32'h0, "status clear");
      msr_access(1'b1, CTL, 32'h20004003);
    end
    pulse(27'h4000000);
    pulse(27'h0000001);
    msr_read(STA, 32'h04000001, "accumulate");
    msr_access(1'b1, CTL, 32'h20000000);
    pulse(27'h0000004);
    check_val("empty mask", 32'h0, {17'h0, notify});
    // Sleeping core without the wake option is left alone
    @(posedge clk_in);
    sleep <= 15'h0002;
    @(posedge clk_in);
    sleep <= 15'h0000;
    msr_access(1'b1, CTL, 32'h00000003);
    pulse(27'h0000002);
    check_val("awake only", 32'h1, {17'h0, notify});
    check_val("no wake", 32'h0, {17'h0, wake});
    // With the wake option the sleeper is woken before it is notified
    msr_access(1'b1, CTL, 32'h40000002);
    pulse(27'h0000008);
    check_val("wake first", 32'h2, {17'h0, wake});
    check_val("no early", 32'h0, {17'h0, notify});
    n = 0;
    while (notify[1] !== 1'b1 && n < 20)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check_val("late notify", 32'h2, {17'h0, notify});
    check_val("wake drop", 32'h0, {17'h0, wake});
    final_report();
  end
endmodule : test_perfmon_global
